/* File: rtl/emsp_pkg.sv */
// Constants for the external memory strobe and select pin block.
// Assumes a single 250 MHz system clock and no register bus.
package emsp_pkg;
  // Widths
  localparam int EMSP_DATA_W = 16;
  localparam int EMSP_ADDR_W = 24;
  // Bus state machine
  typedef enum logic [1:0] {EMSP_IDLE, EMSP_WRITE, EMSP_READ, EMSP_END} emsp_state_e;
  // Strobe length in cycles of the system clock
  localparam int EMSP_STROBE_NS = 8;
  localparam int EMSP_CLK_NS = 4;
  localparam logic [3:0] EMSP_STROBE_CYC = 4'((EMSP_STROBE_NS + EMSP_CLK_NS - 1) / EMSP_CLK_NS);
  // Pull-up control bit positions
  localparam int EMSP_PUR_PS_BIT = 8;
  localparam int EMSP_PUR_DS_BIT = 9;
  // Reset values
  localparam logic EMSP_DRIVE_RST = 1'b0;
  localparam logic [15:0] EMSP_PUR_RST = 16'hFFFF;
endpackage

/* File: rtl/emsp_strobe_pins.sv */
// External memory write strobe, read strobe, selects, address and data pins.
// Assumes the request comes from logic on sys_clk and is held until done.
// What this block does
// - Write strobe is held low for the whole external write cycle.
// - While write strobe is low the data pins drive the write data.
// - Address and selects are valid whenever a strobe is low.
// - With keep-driven clear, write strobe floats while the bus is idle.
// - Strobe pull-up disable bit turns off the write strobe pull-up.
// - Program select goes low for every external program memory access.
// - Out of reset chip select zero acts as program select.
// - With keep-driven clear, chip select zero floats while idle.
// - Data select goes low for every external data memory access.
// - Out of reset chip select one acts as data select.
// - With keep-driven clear, address and control strobes float while idle.
// - Clearing port D pull-up bit 8 disables program select pin pull-up.
// - Clearing port D pull-up bit 9 disables data select pin pull-up.
// - While read strobe is low the data pins are inputs.
`timescale 1ns/1ps
module emsp_strobe_pins
  import emsp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_program,
  input wire logic [EMSP_ADDR_W-1:0] req_addr,
  input wire logic [EMSP_DATA_W-1:0] req_wdata,
  output logic req_done,
  output logic [EMSP_DATA_W-1:0] req_rdata,
  input wire logic bus_keep_driven,
  input wire logic strobe_pullup_disable,
  input wire logic [15:0] port_d_pullup_reg,
  input wire logic cs0_as_gpio,
  input wire logic cs1_as_gpio,
  input wire logic port_d_line_8_out,
  input wire logic port_d_line_8_oe,
  input wire logic port_d_line_9_out,
  input wire logic port_d_line_9_oe,
  output logic port_d_line_8_in,
  output logic port_d_line_9_in,
  output logic write_strobe_n_o,
  output logic write_strobe_n_oe,
  output logic write_strobe_pu,
  output logic read_strobe_n_o,
  output logic read_strobe_n_oe,
  output logic chip_select_zero_n_o,
  output logic chip_select_zero_n_oe,
  output logic chip_select_zero_pu,
  output logic chip_select_one_n_o,
  output logic chip_select_one_n_oe,
  output logic chip_select_one_pu,
  output logic [EMSP_ADDR_W-1:0] addr_o,
  output logic addr_oe,
  input wire logic [EMSP_DATA_W-1:0] data_i,
  output logic [EMSP_DATA_W-1:0] data_o,
  output logic data_oe,
  input wire logic cs0_pin_i,
  input wire logic cs1_pin_i
);

  emsp_state_e state_r;
  logic [3:0] cnt_r;
  logic [EMSP_DATA_W-1:0] data_s1_r;
  logic [EMSP_DATA_W-1:0] data_s2_r;
  logic cs0_s1_r;
  logic cs0_s2_r;
  logic cs1_s1_r;
  logic cs1_s2_r;
  logic active;
  logic rd_access_r;
  logic we_nxt;
  logic re_nxt;

  // Pin input synchronisers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      data_s1_r <= '0;
      data_s2_r <= '0;
      cs0_s1_r <= 1'b1;
      cs0_s2_r <= 1'b1;
      cs1_s1_r <= 1'b1;
      cs1_s2_r <= 1'b1;
    end
    else
    begin
      data_s1_r <= data_i;
      data_s2_r <= data_s1_r;
      cs0_s1_r <= cs0_pin_i;
      cs0_s2_r <= cs0_s1_r;
      cs1_s1_r <= cs1_pin_i;
      cs1_s2_r <= cs1_s1_r;
    end
  end

  // Access sequencer: strobe phase, then one end cycle with strobes high
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= EMSP_IDLE;
      cnt_r <= 4'h0;
      rd_access_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        EMSP_IDLE:
        begin
          if (req_valid)
          begin
            state_r <= req_write ? EMSP_WRITE : EMSP_READ;
            cnt_r <= EMSP_STROBE_CYC;
            rd_access_r <= !req_write; // Only reads update the read data
          end
        end
        EMSP_WRITE, EMSP_READ:
        begin
          if (cnt_r == 4'h1)
            state_r <= EMSP_END;
          cnt_r <= cnt_r - 4'h1;
        end
        EMSP_END:
          state_r <= EMSP_IDLE;
        default:
          state_r <= EMSP_IDLE;
      endcase
    end
  end

  // Strobe levels for the coming cycle
  always_comb
  begin
    we_nxt = 1'b1;
    re_nxt = 1'b1;
    if (state_r == EMSP_IDLE && req_valid)
    begin
      we_nxt = !req_write;
      re_nxt = req_write;
    end
    else if (state_r == EMSP_WRITE && cnt_r != 4'h1)
      we_nxt = 1'b0;
    else if (state_r == EMSP_READ && cnt_r != 4'h1)
      re_nxt = 1'b0;
  end

  assign active = (state_r != EMSP_IDLE) || req_valid;

  // Strobes, selects, address and data drivers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      write_strobe_n_o <= 1'b1;
      write_strobe_n_oe <= 1'b0;
      read_strobe_n_o <= 1'b1;
      read_strobe_n_oe <= 1'b0;
      chip_select_zero_n_o <= 1'b1;
      chip_select_zero_n_oe <= 1'b0;
      chip_select_one_n_o <= 1'b1;
      chip_select_one_n_oe <= 1'b0;
      addr_o <= '0;
      addr_oe <= 1'b0;
      data_o <= '0;
      data_oe <= 1'b0;
    end
    else
    begin
      write_strobe_n_o <= we_nxt;
      read_strobe_n_o <= re_nxt;
      // Float control and address when idle unless kept driven
      write_strobe_n_oe <= bus_keep_driven || active;
      read_strobe_n_oe <= bus_keep_driven || active;
      addr_oe <= bus_keep_driven || active;
      // Select zero is program select by default
      if (cs0_as_gpio)
      begin
        chip_select_zero_n_o <= port_d_line_8_out;
        chip_select_zero_n_oe <= port_d_line_8_oe;
      end
      else
      begin
        chip_select_zero_n_o <= !(req_program && (!we_nxt || !re_nxt));
        chip_select_zero_n_oe <= bus_keep_driven || active;
      end
      // Select one is data select by default
      if (cs1_as_gpio)
      begin
        chip_select_one_n_o <= port_d_line_9_out;
        chip_select_one_n_oe <= port_d_line_9_oe;
      end
      else
      begin
        chip_select_one_n_o <= !(!req_program && (!we_nxt || !re_nxt));
        chip_select_one_n_oe <= bus_keep_driven || active;
      end
      // Address and data held stable through the strobe
      if (state_r == EMSP_IDLE && req_valid)
      begin
        addr_o <= req_addr;
        data_o <= req_wdata;
      end
      data_oe <= !we_nxt;
    end
  end

  // Pull-up controls and GPIO read-back
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      write_strobe_pu <= 1'b1;
      chip_select_zero_pu <= 1'b1;
      chip_select_one_pu <= 1'b1;
      port_d_line_8_in <= 1'b1;
      port_d_line_9_in <= 1'b1;
    end
    else
    begin
      write_strobe_pu <= !strobe_pullup_disable;
      chip_select_zero_pu <= port_d_pullup_reg[EMSP_PUR_PS_BIT];
      chip_select_one_pu <= port_d_pullup_reg[EMSP_PUR_DS_BIT];
      port_d_line_8_in <= cs0_s2_r;
      port_d_line_9_in <= cs1_s2_r;
    end
  end

  // Read data capture at the end of a read strobe and completion pulse
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      req_rdata <= '0;
      req_done <= 1'b0;
    end
    else
    begin
      req_done <= (state_r == EMSP_END);
      if (state_r == EMSP_END && rd_access_r)
        req_rdata <= data_s2_r;
    end
  end

  // Checks
  property p_wr_data;
    @(posedge sys_clk) disable iff (!resetn)
      !write_strobe_n_o |-> data_oe;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("data not driven under write strobe");

  property p_wr_len;
    @(posedge sys_clk) disable iff (!resetn)
      $fell(write_strobe_n_o) |-> !write_strobe_n_o [*2] ##1 write_strobe_n_o;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe length wrong");

  property p_data_hold;
    @(posedge sys_clk) disable iff (!resetn)
      !write_strobe_n_o && $past(!write_strobe_n_o) |-> $stable(data_o) && $stable(addr_o);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("bus changed under strobe");

  property p_float;
    @(posedge sys_clk) disable iff (!resetn)
      (state_r == EMSP_IDLE && !req_valid && !bus_keep_driven) |=> !write_strobe_n_oe && !addr_oe;
  endproperty
  a_float: assert property (p_float) else $error("idle bus driven");

  property p_sel;
    @(posedge sys_clk) disable iff (!resetn)
      (!cs0_as_gpio && !cs1_as_gpio && (!write_strobe_n_o || !read_strobe_n_o))
        |-> (chip_select_zero_n_o != chip_select_one_n_o);
  endproperty
  a_sel: assert property (p_sel) else $error("select not exclusive");

  property p_rd_in;
    @(posedge sys_clk) disable iff (!resetn)
      !read_strobe_n_o |-> !data_oe;
  endproperty
  a_rd_in: assert property (p_rd_in) else $error("data driven during read");

  property p_pu;
    @(posedge sys_clk) disable iff (!resetn)
      ##1 (write_strobe_pu == !$past(strobe_pullup_disable));
  endproperty
  a_pu: assert property (p_pu) else $error("strobe pull-up wrong");

  property p_done;
    @(posedge sys_clk) disable iff (!resetn)
      (state_r == EMSP_IDLE && req_valid) |-> ##4 req_done;
  endproperty
  a_done: assert property (p_done) else $error("access not completed");

  c_write: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(write_strobe_n_o));
  c_read: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(read_strobe_n_o));
  c_float: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(addr_oe));
endmodule

/* File: bench/emsp_sram_model.sv */
// External static memory model on the resolved strobe, select and data pins.
// Assumes pins settle by the falling edge of sys_clk; data lines have no pull.
`timescale 1ns/1ps
module emsp_sram_model
  import emsp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic ps_n,
  input wire logic ds_n,
  input wire logic [EMSP_ADDR_W-1:0] addr,
  input wire logic [EMSP_DATA_W-1:0] wdata,
  output logic [EMSP_DATA_W-1:0] rdata
);
  logic [EMSP_DATA_W-1:0] mem [32];
  logic [EMSP_DATA_W-1:0] data_r;
  logic [4:0] idx_r;
  logic we_low_r = 1'b0;
  logic [1:0] hold_r = 2'h0;
  initial rdata = 16'h0000;
  // Latch on strobe rise, drive read data with a short hold, then garbage
  always @(negedge sys_clk)
  begin
    we_low_r <= !we_n && (!ps_n || !ds_n);
    if (we_low_r && we_n)
      mem[idx_r] <= data_r;
    if (!we_n)
    begin
      idx_r <= {ps_n, addr[3:0]};
      data_r <= wdata;
    end
    if (!re_n && (!ps_n || !ds_n))
    begin
      hold_r <= 2'h2;
      rdata <= mem[{ps_n, addr[3:0]}];
    end
    else if (hold_r != 2'h0)
      hold_r <= hold_r - 2'h1;
    else
      rdata <= ~rdata;
  end
endmodule

/* File: bench/emsp_strobe_pins_tb.sv */
// Self-checking bench for the external memory strobe and select pins.
// Assumes the memory model in emsp_sram_model and pins resolved here.
`timescale 1ns/1ps
module emsp_strobe_pins_tb
  import emsp_pkg::*;
;
  logic sys_clk, resetn, req_valid, req_write, req_program, req_done;
  logic bus_keep_driven, strobe_pullup_disable, cs0_as_gpio, cs1_as_gpio;
  logic port_d_line_8_out, port_d_line_8_oe, port_d_line_9_out, port_d_line_9_oe;
  logic port_d_line_8_in, port_d_line_9_in, write_strobe_n_o, write_strobe_n_oe;
  logic write_strobe_pu, read_strobe_n_o, read_strobe_n_oe, addr_oe, data_oe;
  logic chip_select_zero_n_o, chip_select_zero_n_oe, chip_select_zero_pu;
  logic chip_select_one_n_o, chip_select_one_n_oe, chip_select_one_pu;
  logic cs0_pin_i, cs1_pin_i, we_pin, re_pin;
  logic [EMSP_ADDR_W-1:0] req_addr, addr_o;
  logic [EMSP_DATA_W-1:0] req_wdata, req_rdata, data_i, data_o, mdl_q, exp_rd;
  logic [15:0] port_d_pullup_reg;
  logic tgl = 1'b0;
  int n_errors = 0;
  int tests_run = 0;
  // Pin levels: driver, else pull-up, else a toggling float; read strobe reads high when not driven
  assign we_pin = write_strobe_n_oe ? write_strobe_n_o : (write_strobe_pu | tgl);
  assign re_pin = read_strobe_n_oe ? read_strobe_n_o : 1'b1;
  assign cs0_pin_i = chip_select_zero_n_oe ? chip_select_zero_n_o : (chip_select_zero_pu | tgl);
  assign cs1_pin_i = chip_select_one_n_oe ? chip_select_one_n_o : (chip_select_one_pu | tgl);
  assign data_i = data_oe ? data_o : mdl_q;
  emsp_strobe_pins dut_u (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .req_valid(req_valid),
    .req_write(req_write),
    .req_program(req_program),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .req_done(req_done),
    .req_rdata(req_rdata),
    .bus_keep_driven(bus_keep_driven),
    .strobe_pullup_disable(strobe_pullup_disable),
    .port_d_pullup_reg(port_d_pullup_reg),
    .cs0_as_gpio(cs0_as_gpio),
    .cs1_as_gpio(cs1_as_gpio),
    .port_d_line_8_out(port_d_line_8_out),
    .port_d_line_8_oe(port_d_line_8_oe),
    .port_d_line_9_out(port_d_line_9_out),
    .port_d_line_9_oe(port_d_line_9_oe),
    .port_d_line_8_in(port_d_line_8_in),
    .port_d_line_9_in(port_d_line_9_in),
    .write_strobe_n_o(write_strobe_n_o),
    .write_strobe_n_oe(write_strobe_n_oe),
    .write_strobe_pu(write_strobe_pu),
    .read_strobe_n_o(read_strobe_n_o),
    .read_strobe_n_oe(read_strobe_n_oe),
    .chip_select_zero_n_o(chip_select_zero_n_o),
    .chip_select_zero_n_oe(chip_select_zero_n_oe),
    .chip_select_zero_pu(chip_select_zero_pu),
    .chip_select_one_n_o(chip_select_one_n_o),
    .chip_select_one_n_oe(chip_select_one_n_oe),
    .chip_select_one_pu(chip_select_one_pu),
    .addr_o(addr_o),
    .addr_oe(addr_oe),
    .data_i(data_i),
    .data_o(data_o),
    .data_oe(data_oe),
    .cs0_pin_i(cs0_pin_i),
    .cs1_pin_i(cs1_pin_i)
  );
  emsp_sram_model mdl_u (.sys_clk(sys_clk), .we_n(we_pin), .re_n(re_pin), .ps_n(cs0_pin_i),
    .ds_n(cs1_pin_i), .addr(addr_o), .wdata(data_i), .rdata(mdl_q));
  // Clock and float pattern
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) tgl <= ~tgl;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One access; d is write data or expected read data; done pulses in the fifth cycle
  task automatic acc(input logic w, input logic p, input logic [23:0] a, input logic [15:0] d);
    int lows;
    lows = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_program <= p;
    req_addr <= a;
    req_wdata <= d;
    if (!w)
      exp_rd = d;
    for (int i = 0; i < 5; i++)
    begin
      @(negedge sys_clk);
      chk(req_done, i == 4);
      if (i == 4)
        chk(req_rdata, exp_rd);
      if (we_pin === 1'b0)
      begin
        lows++;
        chk({data_oe, data_o}, {1'b1, d});
        chk(addr_o, a);
        chk({cs0_pin_i, cs1_pin_i}, {!p, p});
      end
      if (re_pin === 1'b0)
      begin
        lows++;
        chk({data_oe, cs0_pin_i, cs1_pin_i, addr_o}, {1'b0, !p, p, a});
      end
      @(posedge sys_clk);
      // Drop the request before the done cycle ends so it is not taken again
      if (i == 3)
        req_valid <= 1'b0;
    end
    chk(lows, 2);
  endtask
  // Idle bus: drivers follow keep-driven, pull-ups follow their controls
  task automatic idle(input int n);
    req_valid <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      @(negedge sys_clk);
      chk(req_done, 1'b0);
      if (i > 1)
      begin
        chk({write_strobe_n_oe, read_strobe_n_oe, chip_select_zero_n_oe, chip_select_one_n_oe,
          addr_oe}, {5{bus_keep_driven}});
        chk({write_strobe_pu, chip_select_zero_pu, chip_select_one_pu}, {!strobe_pullup_disable,
          port_d_pullup_reg[EMSP_PUR_PS_BIT], port_d_pullup_reg[EMSP_PUR_DS_BIT]});
      end
      @(posedge sys_clk);
    end
  endtask
  // Main sequence
  initial
  begin
    {resetn, req_valid, req_write, req_program, bus_keep_driven, strobe_pullup_disable} = 6'h00;
    {cs0_as_gpio, cs1_as_gpio, port_d_line_8_out, port_d_line_8_oe} = 4'h0;
    {port_d_line_9_out, port_d_line_9_oe} = 2'h0;
    req_addr = 24'h000000;
    req_wdata = 16'h0000;
    exp_rd = 16'h0000;
    port_d_pullup_reg = 16'hFFFF;
    repeat (15) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({write_strobe_n_oe, read_strobe_n_oe, chip_select_zero_n_oe, chip_select_one_n_oe,
      addr_oe, data_oe, req_done}, 7'h00);
    chk({write_strobe_pu, chip_select_zero_pu, chip_select_one_pu}, 3'h7);
    @(posedge sys_clk);
    resetn <= 1'b1;
    idle(4);
    acc(1'b1, 1'b1, 24'hABCDE3, 16'h1234);
    acc(1'b1, 1'b0, 24'h000013, 16'hBEEF);
    acc(1'b0, 1'b1, 24'hABCDE3, 16'h1234);
    acc(1'b0, 1'b0, 24'h000013, 16'hBEEF);
    idle(4);
    bus_keep_driven <= 1'b1;
    idle(4);
    acc(1'b1, 1'b0, 24'h000005, 16'h5A5A);
    acc(1'b0, 1'b0, 24'h000005, 16'h5A5A);
    idle(4);
    strobe_pullup_disable <= 1'b1;
    port_d_pullup_reg <= 16'hFEFF;
    idle(4);
    strobe_pullup_disable <= 1'b0;
    port_d_pullup_reg <= 16'h0100;
    {cs0_as_gpio, cs1_as_gpio, port_d_line_8_oe, port_d_line_9_oe} <= 4'hF;
    {port_d_line_8_out, port_d_line_9_out} <= 2'b01;
    idle(6);
    chk({port_d_line_8_in, port_d_line_9_in}, 2'b01);
    tally_and_finish;
  end
  // Watchdog far beyond the expected run length
  initial
  begin
    repeat (2000) @(posedge sys_clk);
    n_errors++;
    tally_and_finish;
  end
endmodule
